/* ptl_pkg.sv */
// package: register offsets, reset values and field positions for the programmable logic lookup
package ptl_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] PTL_ADDR_TABLE_THREE = 8'h14; // truth table driving io[4]
  localparam logic [7:0] PTL_ADDR_TABLE_FOUR = 8'h15; // truth table driving io[3]
  localparam logic [7:0] PTL_ADDR_ADVANCED = 8'hAB; // advanced settings
  localparam logic [7:0] PTL_RST_TABLE = 8'h00; // table reset value
  localparam logic [7:0] PTL_RST_ADVANCED = 8'h00; // advanced reset value
  localparam logic [7:0] PTL_READ_UNMAPPED = 8'h00; // unmapped address reads zero
  // ****************************************
  // field positions
  // ****************************************
  localparam int PTL_BOOST_BIT = 1; // boost enable bit in advanced settings
  localparam int PTL_OUT_HI_BIT = 4; // io bit driven by table three
  localparam int PTL_OUT_LO_BIT = 3; // io bit driven by table four
  localparam int PTL_SEL_MSB = 2; // top bit of the 3-bit lookup index
  // ****************************************
  // low bank logic modes
  // ****************************************
  typedef enum logic [1:0]
  {
    PTL_MODE_OFF = 2'h0,
    PTL_MODE_3TO1 = 2'h1,
    PTL_MODE_3TO2 = 2'h2,
    PTL_MODE_RSVD = 2'h3
  } ptl_mode_e;
endpackage

/* ptl_lut.sv */
// module: combinational 3-input lookup of one 8-bit truth table
`timescale 1ns/1ps
module ptl_lut
(
  input wire logic [7:0] table_bits, // truth table contents
  input wire logic [2:0] sel, // lookup index
  output logic lut_out // selected table bit
);
  // ****************************************
  // lookup
  // ****************************************
  // index 7 picks bit 7, index 0 picks bit 0
  always_comb
  begin
    lut_out = table_bits[sel];
  end
endmodule

/* ptl_lookup.sv */
// module: low bank three-to-two programmable logic lookup with its registers
// Overview of operation
// - io[4] is table three bit at io[2:0]
// - io[3] is table four bit at io[2:0]
// - tables act only in three-to-two mode
// - advanced bit 1 enables boost, resets off
`timescale 1ns/1ps
module ptl_lookup
  import ptl_pkg::*;
(
  input wire logic clk, // 25 mhz core clock
  input wire logic rst_n, // synchronous active low reset
  input wire logic reg_wr, // one-cycle register write strobe
  input wire logic reg_rd, // one-cycle register read strobe
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire ptl_pkg::ptl_mode_e low_bank_logic_mode, // low bank mode field
  input wire logic [2:0] io_in, // pad inputs io[2:0], asynchronous
  output logic [7:0] reg_rdata, // read data, registered
  output logic io_hi_out, // logic value for io[4]
  output logic io_lo_out, // logic value for io[3]
  output logic io_hi_oe_n, // io[4] drive enable, low drives
  output logic io_lo_oe_n, // io[3] drive enable, low drives
  output logic boost_en // boost mode control
);
  import ptl_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] table_three_ff; // logic_truth_table_three
  logic [7:0] table_four_ff; // logic_truth_table_four
  logic [7:0] advanced_ff; // advanced_settings
  logic [7:0] rdata_ff; // read data holding
  logic [7:0] nxt_table_three;
  logic [7:0] nxt_table_four;
  logic [7:0] nxt_advanced;
  logic [7:0] nxt_rdata;

  // ****************************************
  // address decode
  // ****************************************
  // one hit flag per mapped register
  typedef struct packed
  {
    logic table_three; // logic_truth_table_three addressed
    logic table_four; // logic_truth_table_four addressed
    logic advanced; // advanced_settings addressed
  } ptl_hit_s;

  // shared by the write and read paths so both always agree on the map
  function automatic ptl_hit_s reg_hit(input logic [7:0] addr);
    ptl_hit_s hit; // decoded flags
    hit.table_three = (addr == PTL_ADDR_TABLE_THREE);
    hit.table_four = (addr == PTL_ADDR_TABLE_FOUR);
    hit.advanced = (addr == PTL_ADDR_ADVANCED);
    return hit;
  endfunction

  ptl_hit_s addr_hit; // decode of the current bus address
  assign addr_hit = reg_hit(reg_addr);

  // next register values from the write and read strobes
  always_comb
  begin
    nxt_table_three = table_three_ff;
    nxt_table_four = table_four_ff;
    nxt_advanced = advanced_ff;
    nxt_rdata = rdata_ff;
    // unmapped writes match no flag and change nothing
    if (reg_wr && addr_hit.table_three)
    begin
      nxt_table_three = reg_wdata;
    end
    if (reg_wr && addr_hit.table_four)
    begin
      nxt_table_four = reg_wdata;
    end
    // reserved bits stored as written; host keeps them zero
    if (reg_wr && addr_hit.advanced)
    begin
      nxt_advanced = reg_wdata;
    end
    // a read in the same cycle as a write returns the old value
    if (reg_rd)
    begin
      if (addr_hit.table_three)
      begin
        nxt_rdata = table_three_ff;
      end
      else if (addr_hit.table_four)
      begin
        nxt_rdata = table_four_ff;
      end
      else if (addr_hit.advanced)
      begin
        nxt_rdata = advanced_ff;
      end
      else
      begin
        // unmapped reads give zero rather than a stale value
        nxt_rdata = PTL_READ_UNMAPPED;
      end
    end
  end

  // register stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      table_three_ff <= PTL_RST_TABLE;
      table_four_ff <= PTL_RST_TABLE;
      advanced_ff <= PTL_RST_ADVANCED; // boost off after reset
      rdata_ff <= PTL_READ_UNMAPPED;
    end
    else
    begin
      table_three_ff <= nxt_table_three;
      table_four_ff <= nxt_table_four;
      advanced_ff <= nxt_advanced;
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // input synchroniser
  // ****************************************
  // pads are asynchronous: three stages, change taken once stages two and three agree
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] sel_ff; // accepted index
  logic [2:0] nxt_sel;

  // accept each bit only when the last two stages agree
  always_comb
  begin
    for (int i = 0; i <= PTL_SEL_MSB; i++)
    begin
      nxt_sel[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : sel_ff[i];
    end
  end

  // synchroniser registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
      sel_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= io_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      sel_ff <= nxt_sel;
    end
  end

  // ****************************************
  // lookup
  // ****************************************
  // lookup is purely combinational; the only latency is the output flop
  logic lut_hi; // table three result
  logic lut_lo; // table four result

  ptl_lut u_lut_hi
  (
    .table_bits(table_three_ff),
    .sel(nxt_sel),
    .lut_out(lut_hi)
  );

  ptl_lut u_lut_lo
  (
    .table_bits(table_four_ff),
    .sel(nxt_sel),
    .lut_out(lut_lo)
  );

  // ****************************************
  // outputs
  // ****************************************
  logic out_hi_ff;
  logic out_lo_ff;
  logic oe_n_ff;
  logic nxt_out_hi;
  logic nxt_out_lo;
  logic nxt_oe_n;

  // tables drive io[4:3] only in three-to-two mode, else released
  always_comb
  begin
    if (low_bank_logic_mode == PTL_MODE_3TO2)
    begin
      nxt_out_hi = lut_hi;
      nxt_out_lo = lut_lo;
      nxt_oe_n = 1'b0;
    end
    else
    begin
      nxt_out_hi = 1'b0;
      nxt_out_lo = 1'b0;
      nxt_oe_n = 1'b1;
    end
  end

  // output flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_hi_ff <= 1'b0;
      out_lo_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end
    else
    begin
      out_hi_ff <= nxt_out_hi;
      out_lo_ff <= nxt_out_lo;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign io_hi_out = out_hi_ff;
  assign io_lo_out = out_lo_ff;
  assign io_hi_oe_n = oe_n_ff;
  assign io_lo_oe_n = oe_n_ff;
  assign boost_en = advanced_ff[PTL_BOOST_BIT];
  assign reg_rdata = rdata_ff;
endmodule

/* ptl_lookup_assertions.sv */
// checker: port assertions for the lookup block
`timescale 1ns/1ps
module ptl_lookup_chk
  import ptl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire ptl_pkg::ptl_mode_e low_bank_logic_mode,
  input wire logic [2:0] io_in,
  input wire logic [7:0] reg_rdata,
  input wire logic io_hi_out,
  input wire logic io_lo_out,
  input wire logic io_hi_oe_n,
  input wire logic io_lo_oe_n,
  input wire logic boost_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // table mirror and quiet-cycle count
  // ****************************************
  logic [7:0] t3_ff, t4_ff; // mirrored tables
  logic [2:0] io_ff, q_ff; // last index, quiet edges
  wire on = low_bank_logic_mode == PTL_MODE_3TO2;
  // quiet means mode on, index steady, no write: long enough to cover sync plus output flop
  always_ff @(posedge clk)
  begin
    io_ff <= io_in;
    t3_ff <= !rst_n ? 8'h00 : (reg_wr && reg_addr == PTL_ADDR_TABLE_THREE) ? reg_wdata : t3_ff;
    t4_ff <= !rst_n ? 8'h00 : (reg_wr && reg_addr == PTL_ADDR_TABLE_FOUR) ? reg_wdata : t4_ff;
    q_ff <= (!rst_n || !on || reg_wr || io_in != io_ff) ? 3'h0 : q_ff + {2'h0, q_ff != 3'h7};
  end
  sequence s_adv_wr;
    reg_wr && reg_addr == PTL_ADDR_ADVANCED;
  endsequence
  chk_hi_lookup: assert property (q_ff > 3'h5 |-> io_hi_out == t3_ff[io_ff]) else $error("hi out off table");
  chk_lo_lookup: assert property (q_ff > 3'h5 |-> io_lo_out == t4_ff[io_ff]) else $error("lo out off table");
  chk_mode_off: assert property (!on |=> io_hi_oe_n && io_lo_oe_n && !io_hi_out && !io_lo_out)
    else $error("pins driven outside mode");
  chk_mode_on: assert property (on |=> !io_hi_oe_n && !io_lo_oe_n) else $error("pins not driven");
  chk_boost_write: assert property (s_adv_wr |=> boost_en == $past(reg_wdata[1])) else $error("boost not set");
  chk_boost_hold: assert property (!(reg_wr && reg_addr == PTL_ADDR_ADVANCED) |=> $stable(boost_en))
    else $error("boost moved");
  chk_read_three: assert property (reg_rd && reg_addr == PTL_ADDR_TABLE_THREE |=> reg_rdata == $past(t3_ff))
    else $error("table three read");
  chk_read_four: assert property (reg_rd && reg_addr == PTL_ADDR_TABLE_FOUR |=> reg_rdata == $past(t4_ff))
    else $error("table four read");
endmodule
bind ptl_lookup ptl_lookup_chk i_chk (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .low_bank_logic_mode(low_bank_logic_mode), .io_in(io_in),
  .reg_rdata(reg_rdata), .io_hi_out(io_hi_out), .io_lo_out(io_lo_out), .io_hi_oe_n(io_hi_oe_n),
  .io_lo_oe_n(io_lo_oe_n), .boost_en(boost_en));

/* ptl_host.sv */
// host model: register writes and reads on the strobe bus
`timescale 1ns/1ps
module ptl_host
  import ptl_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // one-cycle write; a released bus shows the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_wr, reg_addr} <= {1'h1, a};
    reg_wdata <= (a == PTL_ADDR_ADVANCED) ? (d & 8'h02) : d;
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'h0, ~a, ~d};
  endtask
  // one-cycle read, data taken a full cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    {reg_rd, reg_addr} <= {1'h1, a};
    @(negedge clk);
    {reg_rd, reg_addr} <= {1'h0, ~a};
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule

/* ptl_lookup_tb.sv */
// testbench: reset, lookup, modes and boost of the lookup block
`timescale 1ns/1ps
module ptl_lookup_tb
  import ptl_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  ptl_mode_e mode = PTL_MODE_OFF;
  logic [2:0] io = 3'h0;
  logic wr, rd, hi, lo, hoe, loe, bst;
  logic [7:0] addr, wdata, rdata, v;
  int errors = 0;
  int comparisons = 0;
  initial forever #20 clk = ~clk;
  ptl_host i_ptl_host (.clk(clk), .reg_rdata(rdata), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
  ptl_lookup i_ptl_lookup (.clk(clk), .rst_n(rst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .low_bank_logic_mode(mode), .io_in(io), .reg_rdata(rdata), .io_hi_out(hi), .io_lo_out(lo),
    .io_hi_oe_n(hoe), .io_lo_oe_n(loe), .boost_en(bst));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // every index against both tables, then a rewrite checked at io[4] and read back
  task automatic t_lookup;
    logic [7:0] t3, t4;
    t3 = 8'hB4;
    t4 = 8'h4B;
    i_ptl_host.wr(PTL_ADDR_TABLE_THREE, t3);
    i_ptl_host.wr(PTL_ADDR_TABLE_FOUR, t4);
    mode = PTL_MODE_3TO2;
    for (int i = 0; i < 8; i++)
    begin
      io = 3'(i);
      repeat (8) @(negedge clk);
      check(hi, t3[i]);
      check(lo, t4[i]);
    end
    i_ptl_host.wr(PTL_ADDR_TABLE_THREE, 8'h35);
    repeat (3) @(negedge clk);
    check(hi, 8'h00);
    i_ptl_host.rd(PTL_ADDR_TABLE_THREE, v);
    check(v, 8'h35);
  endtask
  // index 0 drives both pins high, then every other mode must drop them
  task automatic t_modes;
    ptl_mode_e m[3];
    m = '{PTL_MODE_OFF, PTL_MODE_3TO1, PTL_MODE_RSVD};
    io = 3'h0;
    repeat (5) @(negedge clk);
    check({hi, lo, hoe, loe}, 8'h0C);
    foreach (m[k])
    begin
      mode = m[k];
      repeat (2) @(negedge clk);
      check({hi, lo, hoe, loe}, 8'h03);
    end
  endtask
  // boost on and off, reserved bits zero, unmapped place reads zero
  task automatic t_boost;
    i_ptl_host.wr(PTL_ADDR_ADVANCED, 8'hFF);
    check(bst, 8'h01);
    i_ptl_host.rd(PTL_ADDR_ADVANCED, v);
    check(v, 8'h02);
    i_ptl_host.wr(PTL_ADDR_ADVANCED, 8'h00);
    check(bst, 8'h00);
    i_ptl_host.wr(8'h16, 8'hFF);
    check(bst, 8'h00);
    i_ptl_host.rd(8'h16, v);
    check(v, 8'h00);
  endtask
  // reset in mid-run: boost and tables go back to zero, the mode drives again afterwards
  task automatic t_reset;
    i_ptl_host.wr(PTL_ADDR_ADVANCED, 8'h02);
    i_ptl_host.wr(PTL_ADDR_TABLE_THREE, 8'hFF);
    mode = PTL_MODE_3TO2;
    repeat (2) @(negedge clk);
    check({hi, hoe, bst}, 8'h05);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    check({hoe, loe, bst}, 8'h06);
    repeat (8) @(negedge clk);
    check({hi, lo, hoe, loe}, 8'h00);
    i_ptl_host.rd(PTL_ADDR_TABLE_THREE, v);
    check(v, 8'h00);
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    check({hoe, loe, bst}, 8'h06);
    i_ptl_host.rd(PTL_ADDR_TABLE_FOUR, v);
    check(v, 8'h00);
    t_lookup;
    t_modes;
    t_boost;
    t_reset;
    report_and_stop;
  end
endmodule
